// File: design/lt_pkg.sv
// Shared constants and types for the line-scan trigger and event block
package lt_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DETECT = 8'h04;
  localparam logic [7:0] OFS_MULT = 8'h08;
  localparam logic [7:0] OFS_DROP = 8'h0C;
  localparam logic [7:0] OFS_LINES = 8'h10;
  localparam logic [7:0] OFS_INT_PER = 8'h14;
  localparam logic [7:0] OFS_VT_LIM = 8'h18;
  localparam logic [7:0] OFS_EVENTS = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  // Control register field positions
  localparam int CTRL_ENC_EN = 0;
  localparam int CTRL_DIR_LO = 1;
  localparam int CTRL_FT_EN = 3;
  localparam int CTRL_SRC_INT = 4;
  localparam int CTRL_ACQ_RUN = 5;
  localparam int CTRL_AUTO_DLY = 6;
  // Event register bit positions
  localparam int EV_TRIG_USED = 0;
  localparam int EV_TRIG_IGN = 1;
  localparam int EV_SOF = 2;
  localparam int EV_EOF = 3;
  localparam int EV_OVERFLOW = 4;
  localparam int EV_FVAL = 5;
  localparam int EV_PCLK_ABS = 6;
  localparam int EV_PCLK_PRES = 7;
  localparam int EV_FRAME_LOST = 8;
  localparam int EV_VTIMEOUT = 9;
  localparam int EV_TOO_SLOW = 10;
  localparam int EV_TOO_FAST = 11;
  localparam int EV_REV_OVF = 12;
  localparam int EV_W = 13;
  // Reset values
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic [6:0] DETECT_RST = 7'h04;
  localparam logic [7:0] MULT_RST = 8'h01;
  localparam logic [7:0] DROP_RST = 8'h00;
  localparam logic [15:0] LINES_RST = 16'h0001;
  localparam logic [15:0] INT_PER_RST = 16'h0000;
  localparam logic [23:0] VT_LIM_RST = 24'h00_0000;
  // Direction codes
  localparam logic [1:0] DIR_IGNORE = 2'h0;
  localparam logic [1:0] DIR_AB = 2'h1;
  localparam logic [1:0] DIR_BA = 2'h2;
  // Frame trigger detection codes
  localparam logic [6:0] DET_LOW = 7'h01;
  localparam logic [6:0] DET_HIGH = 7'h02;
  localparam logic [6:0] DET_RISE = 7'h04;
  localparam logic [6:0] DET_FALL = 7'h08;
  localparam logic [6:0] DET_DUAL_RISE = 7'h20;
  localparam logic [6:0] DET_DUAL_FALL = 7'h40;
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int TRIG_WIDTH_NS = 1000;
  localparam int TRIG_WIDTH_CYC = (TRIG_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PCLK_TO_NS = 10000;
  localparam int PCLK_TO_CYC = PCLK_TO_NS / CLK_PERIOD_NS;
  localparam int TW_W = 6;
  localparam int PC_W = 9;
  localparam logic [TW_W-1:0] TW_LOAD = TW_W'(TRIG_WIDTH_CYC);
  localparam logic [PC_W-1:0] PC_LIMIT = PC_W'(PCLK_TO_CYC);
  localparam logic [7:0] REV_MAX = 8'hFF;
  localparam logic [15:0] PER_MAX = 16'hFFFF;
  // Virtual frame states
  typedef enum logic [1:0] {
    FR_IDLE = 2'b00,
    FR_ARMED = 2'b01,
    FR_STORE = 2'b10
  } fr_st_t;
endpackage : lt_pkg

// File: design/lt_sync2.sv
// Two-flop synchroniser for a bundle of level inputs
module lt_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : lt_sync2

// File: design/linescan_trigger_and_acq_events.sv
// Line trigger conditioning, virtual frame control and acquisition events
//
// Implementation choices: the register addresses and the APB slave port.
module linescan_trigger_and_acq_events
  import lt_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Shaft encoder and frame trigger pins
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic ftrig_1,
  input wire logic ftrig_2,
  // Camera timing
  input wire logic cam_fval,
  input wire logic cam_lval,
  input wire logic cam_pclk,
  output logic line_trig,
  // Storage side
  input wire logic buf_free,
  input wire logic xfer_ready,
  output logic vframe_start,
  output logic line_store,
  output logic frame_active
);
  typedef struct packed {
    logic [6:0] prev;
    logic [6:0] ctrl;
    logic [6:0] detect;
    logic [7:0] mult;
    logic [7:0] drop;
    logic [15:0] lines;
    logic [15:0] int_per;
    logic [23:0] vt_lim;
    logic [EV_W-1:0] ev;
    logic [7:0] rev_cnt;
    logic [15:0] per_cnt;
    logic [15:0] step;
    logic [7:0] mul_rem;
    logic [15:0] mul_tmr;
    logic [7:0] drop_cnt;
    logic [15:0] int_cnt;
    logic busy;
    logic pend;
    logic fast_done;
    logic [TW_W-1:0] tw_cnt;
    logic trig_out;
    logic dual_arm;
    fr_st_t fr_st;
    logic [15:0] lines_left;
    logic fr_start;
    logic ln_store;
    logic [PC_W-1:0] pc_cnt;
    logic pclk_ok;
    logic vt_run;
    logic [23:0] vt_cnt;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } state_t;

  state_t s_q, s_d;
  logic rst_sync_n;
  logic [6:0] pins_s;
  logic a, b, t1, t2, fv, lv, pc;

  // Reset release and pin synchronisers share one module
  lt_sync2 #(.W(1)) u_rst_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .d(1'b1),
    .q(rst_sync_n)
  );
  lt_sync2 #(.W(7)) u_pin_sync (
    .clk(ref_clk),
    .rst_n(rst_sync_n),
    .d({enc_a, enc_b, ftrig_1, ftrig_2, cam_fval, cam_lval, cam_pclk}),
    .q(pins_s)
  );
  assign {a, b, t1, t2, fv, lv, pc} = pins_s;

  // Spacing of multiplied pulses over one encoder period
  function automatic logic [15:0] spread(input logic [15:0] per, input logic [7:0] m);
    spread = (m > 8'h01) ? per / {8'h00, m} : per;
  endfunction : spread

  // Software readable view of registers
  function automatic logic [31:0] rd_mux(input state_t s, input logic [7:0] ad);
    unique case (ad)
      OFS_CTRL: rd_mux = {25'h000_0000, s.ctrl};
      OFS_DETECT: rd_mux = {25'h000_0000, s.detect};
      OFS_MULT: rd_mux = {24'h00_0000, s.mult};
      OFS_DROP: rd_mux = {24'h00_0000, s.drop};
      OFS_LINES: rd_mux = {16'h0000, s.lines};
      OFS_INT_PER: rd_mux = {16'h0000, s.int_per};
      OFS_VT_LIM: rd_mux = {8'h00, s.vt_lim};
      OFS_EVENTS: rd_mux = {19'h0_0000, s.ev};
      OFS_STATUS: rd_mux = {19'h0_0000, s.pclk_ok, s.fr_st, s.pend, s.busy, s.rev_cnt};
      default: rd_mux = 32'h0000_0000;
    endcase
  endfunction : rd_mux

  // Next state of the whole block
  always_comb begin
    logic a_r, b_r, t1_r, t1_f, t2_r, t2_f, fv_r, fv_f, lv_f, pc_t;
    logic step, a_lead, fwd, accept, mpulse, enc_trig, int_trig, req, issue, fev, hit;
    logic [1:0] dir;
    logic [EV_W-1:0] set;
    s_d = s_q;
    set = '0;
    accept = 1'b0;
    mpulse = 1'b0;
    enc_trig = 1'b0;
    int_trig = 1'b0;
    issue = 1'b0;
    fev = 1'b0;
    hit = 1'b0;
    dir = s_q.ctrl[CTRL_DIR_LO +: 2];
    a_r = a & ~s_q.prev[6];
    b_r = b & ~s_q.prev[5];
    t1_r = t1 & ~s_q.prev[4];
    t1_f = ~t1 & s_q.prev[4];
    t2_r = t2 & ~s_q.prev[3];
    t2_f = ~t2 & s_q.prev[3];
    fv_r = fv & ~s_q.prev[2];
    fv_f = ~fv & s_q.prev[2];
    lv_f = ~lv & s_q.prev[1];
    pc_t = pc ^ s_q.prev[0];
    s_d.prev = pins_s;

    // Encoder step direction from quadrature order
    step = s_q.ctrl[CTRL_ENC_EN] & (a_r | b_r);
    a_lead = (a_r & ~b) | (b_r & a);
    fwd = (dir == DIR_AB) ? a_lead : ~a_lead;
    if (step) begin
      if (dir == DIR_IGNORE) begin
        accept = 1'b1;
      end else if (!fwd) begin
        if (s_q.rev_cnt == REV_MAX) begin
          set[EV_REV_OVF] = 1'b1;
        end else begin
          s_d.rev_cnt = s_q.rev_cnt + 8'h01;
        end
      end else if (s_q.rev_cnt != 8'h00) begin
        s_d.rev_cnt = s_q.rev_cnt - 8'h01;
      end else begin
        accept = 1'b1;
      end
    end

    // Period measurement saturates; a saturated period cannot be divided up
    if (s_q.per_cnt != PER_MAX) begin
      s_d.per_cnt = s_q.per_cnt + 16'h0001;
    end
    if (accept) begin
      s_d.per_cnt = 16'h0000;
      s_d.step = spread(s_q.per_cnt, s_q.mult);
      if (s_q.per_cnt == PER_MAX && s_q.mult > 8'h01) begin
        set[EV_TOO_SLOW] = 1'b1;
      end
    end

    // Multiplier: first pulse at once, the rest one step apart
    if (accept) begin
      mpulse = 1'b1;
      s_d.mul_rem = (s_q.mult > 8'h01) ? s_q.mult - 8'h01 : 8'h00;
      s_d.mul_tmr = spread(s_q.per_cnt, s_q.mult);
    end else if (s_q.mul_rem != 8'h00) begin
      if (s_q.mul_tmr <= 16'h0001) begin
        mpulse = 1'b1;
        s_d.mul_rem = s_q.mul_rem - 8'h01;
        s_d.mul_tmr = s_q.step;
      end else begin
        s_d.mul_tmr = s_q.mul_tmr - 16'h0001;
      end
    end

    // Drop stage sees multiplied pulses only
    if (mpulse) begin
      if (s_q.drop_cnt == 8'h00) begin
        enc_trig = 1'b1;
        s_d.drop_cnt = s_q.drop;
      end else begin
        s_d.drop_cnt = s_q.drop_cnt - 8'h01;
      end
    end

    // Internal line trigger generator, period 0 stops it
    s_d.int_cnt = s_q.int_cnt + 16'h0001;
    if (s_q.int_per != 16'h0000 && s_q.int_cnt >= s_q.int_per - 16'h0001) begin
      int_trig = 1'b1;
      s_d.int_cnt = 16'h0000;
    end
    req = s_q.ctrl[CTRL_SRC_INT] ? int_trig : enc_trig;

    // Auto delay holds one trigger while the camera line is busy
    if (lv_f) begin
      s_d.busy = 1'b0;
    end
    if (s_q.pend && !s_d.busy) begin
      issue = 1'b1;
      s_d.pend = 1'b0;
    end else if (req) begin
      if (!s_d.busy || !s_q.ctrl[CTRL_AUTO_DLY]) begin
        issue = 1'b1;
      end else if (!s_q.pend) begin
        s_d.pend = 1'b1;
      end else if (!s_q.fast_done) begin
        set[EV_TOO_FAST] = 1'b1;
        s_d.fast_done = 1'b1;
      end
    end
    if (s_q.tw_cnt != '0) begin
      s_d.tw_cnt = s_q.tw_cnt - 1'b1;
    end
    if (issue) begin
      s_d.busy = 1'b1;
      s_d.tw_cnt = TW_LOAD;
    end
    s_d.trig_out = (s_d.tw_cnt != '0);

    // Frame trigger qualification; level modes count only when idle
    unique case (s_q.detect)
      DET_LOW: hit = ~t1 & (s_q.fr_st == FR_IDLE);
      DET_HIGH: hit = t1 & (s_q.fr_st == FR_IDLE);
      DET_RISE: hit = t1_r;
      DET_FALL: hit = t1_f;
      DET_DUAL_RISE: hit = t2_r & s_q.dual_arm;
      DET_DUAL_FALL: hit = t2_f & s_q.dual_arm;
      default: hit = 1'b0;
    endcase
    if ((s_q.detect == DET_DUAL_RISE && t1_r) || (s_q.detect == DET_DUAL_FALL && t1_f)) begin
      s_d.dual_arm = 1'b1;
    end else if (hit) begin
      s_d.dual_arm = 1'b0;
    end
    fev = hit & s_q.ctrl[CTRL_FT_EN];

    // Virtual frame sequencing
    s_d.fr_start = 1'b0;
    s_d.ln_store = 1'b0;
    unique case (s_q.fr_st)
      FR_IDLE: begin
        if (s_q.ctrl[CTRL_ACQ_RUN] && (fev || !s_q.ctrl[CTRL_FT_EN])) begin
          s_d.fr_st = FR_ARMED;
          set[EV_TRIG_USED] = fev;
        end
      end
      FR_ARMED: begin
        if (issue) begin
          s_d.fast_done = 1'b0;
          s_d.vt_run = 1'b1;
          s_d.vt_cnt = 24'h00_0000;
          if (!buf_free) begin
            set[EV_FRAME_LOST] = 1'b1;
            s_d.fr_st = FR_IDLE;
          end else begin
            s_d.fr_st = FR_STORE;
            s_d.fr_start = 1'b1;
            s_d.lines_left = s_q.lines;
          end
        end
      end
      FR_STORE: begin
        if (lv_f) begin
          s_d.ln_store = 1'b1;
          s_d.lines_left = s_q.lines_left - 16'h0001;
          if (s_q.lines_left <= 16'h0001) begin
            s_d.fr_st = FR_IDLE;
          end
        end
      end
      default: s_d.fr_st = FR_IDLE;
    endcase
    if (fev && s_q.fr_st != FR_IDLE) begin
      set[EV_TRIG_IGN] = 1'b1;
    end
    if (!s_q.ctrl[CTRL_ACQ_RUN]) begin
      s_d.fr_st = FR_IDLE;
    end

    // Camera frame and bandwidth events
    set[EV_FVAL] = fv_r;
    set[EV_SOF] = fv_r & s_q.ctrl[CTRL_ACQ_RUN];
    set[EV_EOF] = fv_f & s_q.ctrl[CTRL_ACQ_RUN];
    if (s_q.fr_st == FR_STORE && lv && !xfer_ready) begin
      set[EV_OVERFLOW] = 1'b1;
    end

    // Vertical timeout after a triggered frame, limit 0 disables it
    if (s_q.vt_run) begin
      if (fv_r) begin
        s_d.vt_run = 1'b0;
      end else if (s_q.vt_lim != 24'h00_0000 && s_q.vt_cnt >= s_q.vt_lim) begin
        set[EV_VTIMEOUT] = 1'b1;
        s_d.vt_run = 1'b0;
      end else begin
        s_d.vt_cnt = s_q.vt_cnt + 24'h00_0001;
      end
    end

    // Pixel clock watchdog on sampled toggles; slow clocks only
    if (pc_t) begin
      s_d.pc_cnt = '0;
      if (!s_q.pclk_ok) begin
        set[EV_PCLK_PRES] = 1'b1;
        s_d.pclk_ok = 1'b1;
      end
    end else if (s_q.pc_cnt >= PC_LIMIT - 1'b1) begin
      if (s_q.pclk_ok) begin
        set[EV_PCLK_ABS] = 1'b1;
        s_d.pclk_ok = 1'b0;
      end
    end else begin
      s_d.pc_cnt = s_q.pc_cnt + 1'b1;
    end

    // APB slave: one wait state, unmapped address errors
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    if (psel && penable && !s_q.pready) begin
      s_d.pready = 1'b1;
      s_d.prdata = pwrite ? 32'h0000_0000 : rd_mux(s_q, paddr);
      s_d.pslverr = (paddr > OFS_STATUS) || (paddr[1:0] != 2'b00);
      if (pwrite) begin
        unique case (paddr)
          OFS_CTRL: s_d.ctrl = pwdata[6:0];
          OFS_DETECT: s_d.detect = pwdata[6:0];
          OFS_MULT: s_d.mult = pwdata[7:0];
          OFS_DROP: s_d.drop = pwdata[7:0];
          OFS_LINES: s_d.lines = pwdata[15:0];
          OFS_INT_PER: s_d.int_per = pwdata[15:0];
          OFS_VT_LIM: s_d.vt_lim = pwdata[23:0];
          OFS_EVENTS: s_d.ev = s_q.ev & ~pwdata[EV_W-1:0];
          default: s_d.ev = s_d.ev;
        endcase
      end
    end
    // Set beats a same-cycle clear so no event is lost
    s_d.ev = s_d.ev | set;
  end

  // All block state, set to its reset values by the synchronised reset
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_q <= '0;
      s_q.ctrl <= CTRL_RST;
      s_q.detect <= DETECT_RST;
      s_q.mult <= MULT_RST;
      s_q.drop <= DROP_RST;
      s_q.lines <= LINES_RST;
      s_q.int_per <= INT_PER_RST;
      s_q.vt_lim <= VT_LIM_RST;
      s_q.fr_st <= FR_IDLE;
      s_q.per_cnt <= PER_MAX; // No encoder period known yet, so too slow
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from state flops, except frame_active, which is decoded from fr_st
  assign pready = s_q.pready;
  assign prdata = s_q.prdata;
  assign pslverr = s_q.pslverr;
  assign line_trig = s_q.trig_out;
  assign vframe_start = s_q.fr_start;
  assign line_store = s_q.ln_store;
  assign frame_active = (s_q.fr_st == FR_STORE);
endmodule : linescan_trigger_and_acq_events

// File: tb/lt_checker.sv
// Port checker for the line trigger and event block
module lt_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Trigger and storage outputs
  input wire logic line_trig,
  input wire logic vframe_start,
  input wire logic line_store,
  input wire logic frame_active
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] hi_q;
  // Cycles the camera trigger has stood high
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      hi_q <= 8'h00;
    else
      hi_q <= line_trig ? hi_q + 8'h01 : 8'h00;
  end
  sequence taken_s;
    psel && penable && !pready;
  endsequence
  sequence bad_addr_s;
    paddr > 8'h20 || paddr[1:0] != 2'h0;
  endsequence
  chk_apb_one_wait: assert property (taken_s |=> pready)
    else $error("pready late");
  chk_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  chk_err_decode: assert property (pready |-> pslverr == (paddr > 8'h20 || paddr[1:0] != 2'h0))
    else $error("pslverr wrong");
  chk_err_data: assert property (pready ##0 bad_addr_s |-> prdata == 32'h0000_0000)
    else $error("data on error");
  chk_wr_data_zero: assert property (pready && pwrite |-> prdata == 32'h0000_0000)
    else $error("data on write");
  chk_trig_width: assert property ($fell(line_trig) |-> hi_q == 8'h32)
    else $error("trigger width");
  chk_vstart_pulse: assert property (vframe_start |=> !vframe_start)
    else $error("frame start held");
  chk_store_pulse: assert property (line_store |=> !line_store)
    else $error("line store held");
  chk_vstart_active: assert property (vframe_start |-> ##[0:2] frame_active)
    else $error("frame not active");
endmodule : lt_checker

// File: tb/cam_model.sv
// Camera and pixel clock model facing the line trigger block
module cam_model (
  // Clock
  input wire logic clk,
  // Bench controls
  input wire logic slow,
  input wire logic pclk_on,
  input wire logic fval_req,
  // Camera pins
  input wire logic line_trig,
  output logic cam_fval,
  output logic cam_lval,
  output logic cam_pclk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic trig_q = 1'b0;
  logic fval_q = 1'b0;
  logic [1:0] div_q = 2'h0;
  int cnt = 0;
  // A busy sensor ignores new triggers, so overtriggering loses lines
  always @(posedge clk) begin
    trig_q <= line_trig;
    fval_q <= fval_req;
    if (pclk_on)
      div_q <= div_q + 2'h1;
    if (line_trig && !trig_q && cnt == 0)
      cnt <= slow ? 420 : 30;
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
  // Line valid is the last 20 cycles of each exposure
  assign cam_fval = fval_q;
  assign cam_lval = cnt > 0 && cnt <= 20;
  assign cam_pclk = div_q[1]; // Stands still when switched off
endmodule : cam_model

// File: tb/tb_top.sv
// Self-checking bench for the line trigger and event block
module tb_top
  import lt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err, trig_q = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, line_trig, vframe_start, line_store, frame_active;
  logic enc_a = 0, enc_b = 0, ftrig_1 = 0, ftrig_2 = 0, buf_free = 1, xfer_ready = 1;
  logic slow = 0, pclk_on = 1, fval_req = 0, cam_fval, cam_lval, cam_pclk;
  int error_cnt = 0, total_checks = 0, cyc = 0, trig_cnt = 0, ls_cnt = 0, vs_cnt = 0, b1, b2;
  logic [7:0] oa[7] = '{OFS_CTRL, OFS_DETECT, OFS_MULT, OFS_DROP, OFS_LINES, OFS_INT_PER,
    OFS_VT_LIM};
  logic [31:0] ov[7] = '{32'h0, 32'h4, 32'h1, 32'h0, 32'h1, 32'h0, 32'h0};
  logic [6:0] dc[6] = '{DET_LOW, DET_HIGH, DET_RISE, DET_FALL, DET_DUAL_RISE, DET_DUAL_FALL};
  logic [4:0] ds[6] = '{5'h1F, 5'h0F, 5'h0F, 5'h07, 5'h03, 5'h01};

  linescan_trigger_and_acq_events DUT (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .enc_a(enc_a), .enc_b(enc_b), .ftrig_1(ftrig_1),
    .ftrig_2(ftrig_2), .cam_fval(cam_fval), .cam_lval(cam_lval), .cam_pclk(cam_pclk),
    .line_trig(line_trig), .buf_free(buf_free), .xfer_ready(xfer_ready),
    .vframe_start(vframe_start), .line_store(line_store), .frame_active(frame_active));
  cam_model cam (.clk(ref_clk), .slow(slow), .pclk_on(pclk_on), .fval_req(fval_req),
    .line_trig(line_trig), .cam_fval(cam_fval), .cam_lval(cam_lval), .cam_pclk(cam_pclk));

  // Clock
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  // Output pulse counters and hang guard
  always @(posedge ref_clk) begin
    trig_q <= line_trig;
    if (line_trig === 1'b1 && trig_q === 1'b0)
      trig_cnt++;
    if (line_store === 1'b1)
      ls_cnt++;
    if (vframe_start === 1'b1)
      vs_cnt++;
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wt
  // One APB transfer; waits for pready however long it takes
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic ev(input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, OFS_EVENTS, 32'h0);
    chk("events", rd & m, exp);
  endtask : ev
  task automatic clr();
    apb(1'b1, OFS_EVENTS, 32'h0000_1FFF);
  endtask : clr
  task automatic enc(input logic a, input logic b, input int gap);
    enc_a <= a;
    enc_b <= b;
    wt(gap);
  endtask : enc
  task automatic pulse(input int gap);
    enc(1'b1, 1'b0, gap);
    enc(1'b0, 1'b0, gap);
  endtask : pulse
  task automatic quad(input logic f);
    enc(f, !f, 60);
    enc(1'b1, 1'b1, 60);
    enc(!f, f, 60);
    enc(1'b0, 1'b0, 60);
  endtask : quad

  task automatic t_regs();
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, oa[i], 32'h0);
      chk("reset value", rd, ov[i]);
    end
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status", rd & 32'h0000_0FFF, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
  endtask : t_regs
  task automatic t_encoder();
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b1, OFS_MULT, 32'h2);
    clr();
    pulse(200);
    ev(32'h0000_0400, 32'h0000_0400);
    b1 = trig_cnt;
    pulse(200);
    chk("multiplied", trig_cnt - b1, 32'h2);
    apb(1'b1, OFS_DROP, 32'h1);
    b1 = trig_cnt;
    repeat (3) pulse(200);
    chk("drop after mult", trig_cnt - b1, 32'h3);
    apb(1'b1, OFS_MULT, 32'h1);
    apb(1'b1, OFS_DROP, 32'h0);
    for (int d = 1; d < 3; d++) begin
      apb(1'b1, OFS_CTRL, 32'(1 + 2 * d));
      b1 = trig_cnt;
      quad(d == 2);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("reverse count", rd[7:0], 32'h2);
      quad(d != 2);
      quad(d != 2);
      chk("direction", trig_cnt - b1, 32'h2);
    end
    for (int e = 1; e >= 0; e--) begin
      apb(1'b1, OFS_CTRL, 32'(e));
      b1 = trig_cnt;
      quad(1'b1);
      chk("enable", trig_cnt - b1, 32'(2 * e));
    end
    // Two reverse steps per loop, enough to saturate the reverse counter
    apb(1'b1, OFS_CTRL, 32'h3);
    clr();
    repeat (130) begin
      enc(1'b0, 1'b1, 4);
      enc(1'b1, 1'b1, 4);
      enc(1'b1, 1'b0, 4);
      enc(1'b0, 1'b0, 4);
    end
    ev(32'h0000_1000, 32'h0000_1000);
  endtask : t_encoder
  task automatic t_detect();
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, OFS_DETECT, 32'(dc[i]));
      apb(1'b1, OFS_CTRL, 32'h28);
      for (int j = 0; j < 5; j++) begin
        ftrig_1 <= j == 1;
        ftrig_2 <= j == 3;
        wt(10);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("armed", rd[11:10], 32'(ds[i][4-j]));
      end
      apb(1'b1, OFS_CTRL, 32'h0);
    end
    apb(1'b1, OFS_DETECT, 32'h4);
    apb(1'b1, OFS_CTRL, 32'h20);
    clr();
    ftrig_1 <= 1'b1;
    wt(20);
    ftrig_1 <= 1'b0;
    wt(20);
    ev(32'h3, 32'h0);
    // Leave the frame sequencer idle for the next scenario
    apb(1'b1, OFS_CTRL, 32'h0);
  endtask : t_detect
  task automatic t_frame();
    apb(1'b1, OFS_LINES, 32'h3);
    apb(1'b1, OFS_CTRL, 32'h29);
    clr();
    b1 = ls_cnt;
    b2 = vs_cnt;
    fval_req <= 1'b1;
    xfer_ready <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      ftrig_1 <= k == 0 || k == 2;
      wt(20);
      if (k > 0)
        pulse(120);
    end
    fval_req <= 1'b0;
    xfer_ready <= 1'b1;
    wt(20);
    chk("frame starts", vs_cnt - b2, 32'h1);
    chk("stored lines", ls_cnt - b1, 32'h3);
    ev(32'h3F, 32'h3F);
    apb(1'b1, OFS_CTRL, 32'h0);
    clr();
    fval_req <= 1'b1;
    wt(50);
    fval_req <= 1'b0;
    wt(50);
    ev(32'h2C, 32'h20);
    apb(1'b1, OFS_VT_LIM, 32'h64);
    apb(1'b1, OFS_CTRL, 32'h21);
    buf_free <= 1'b0;
    clr();
    pulse(150);
    ev(32'h300, 32'h300);
    apb(1'b1, OFS_CTRL, 32'h0);
    buf_free <= 1'b1;
    pclk_on <= 1'b0;
    clr();
    wt(600);
    ev(32'hC0, 32'h40);
    pclk_on <= 1'b1;
    wt(20);
    ev(32'h80, 32'h80);
  endtask : t_frame
  task automatic t_internal();
    apb(1'b1, OFS_INT_PER, 32'h64);
    apb(1'b1, OFS_CTRL, 32'h11);
    wt(150);
    b1 = trig_cnt;
    wt(500);
    chk("internal rate", trig_cnt - b1, 32'h5);
    apb(1'b1, OFS_INT_PER, 32'h0);
    wt(2);
    b1 = trig_cnt;
    pulse(100);
    chk("internal only", trig_cnt - b1, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h0);
  endtask : t_internal
  task automatic t_delay();
    apb(1'b1, OFS_CTRL, 32'h41);
    slow <= 1'b1;
    clr();
    b1 = trig_cnt;
    repeat (2) pulse(30);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("pending", rd[9], 32'h1);
    pulse(30);
    ev(32'h800, 32'h800);
    wt(400);
    chk("delayed issue", trig_cnt - b1, 32'h2);
    clr();
    repeat (2) pulse(30);
    ev(32'h800, 32'h0);
    slow <= 1'b0;
    apb(1'b1, OFS_CTRL, 32'h0);
  endtask : t_delay

  // Main sequence
  initial begin
    wt(6);
    rst_n <= 1'b1;
    wt(5);
    t_regs();
    t_encoder();
    t_detect();
    t_frame();
    t_internal();
    t_delay();
    tally_and_finish();
  end
endmodule : tb_top

bind linescan_trigger_and_acq_events lt_checker chk_i (.ref_clk(ref_clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .line_trig(line_trig), .vframe_start(vframe_start),
  .line_store(line_store), .frame_active(frame_active));
